// ==== hw/tmrwo_pkg.sv ====
package tmrwo_pkg;
  // register word indices (printed offsets are not all multiples of four: byte address is index * 4)
  localparam logic [7:0] TMRWO_IDX_CTRL_A = 8'h24;
  localparam logic [7:0] TMRWO_IDX_CTRL_B = 8'h25;
  localparam logic [7:0] TMRWO_IDX_COUNT = 8'h26;
  localparam logic [7:0] TMRWO_IDX_CMP_A = 8'h27;
  localparam logic [7:0] TMRWO_IDX_CMP_B = 8'h28;
  localparam logic [7:0] TMRWO_IDX_IRQ_STAT = 8'h29;
  localparam logic [7:0] TMRWO_IDX_IRQ_MASK = 8'h2a;
  localparam logic [7:0] TMRWO_IDX_PORT = 8'h2b;
  localparam int TMRWO_ADDR_W = 10;
  // control register fields
  localparam int TMRWO_A_OUTA_LSB = 6;
  localparam int TMRWO_A_OUTB_LSB = 4;
  localparam int TMRWO_A_WAVE_LSB = 0;
  localparam int TMRWO_B_WAVE_HI = 3;
  localparam logic [7:0] TMRWO_CTRL_A_WMASK = 8'hf3;
  localparam logic [7:0] TMRWO_CTRL_B_WMASK = 8'h08;
  localparam logic [7:0] TMRWO_RESET_VAL = 8'h00;
  localparam logic [7:0] TMRWO_MAX = 8'hff;
  localparam logic [7:0] TMRWO_BOTTOM = 8'h00;
  // status bit positions
  localparam int TMRWO_ST_OVF = 0;
  localparam int TMRWO_ST_MA = 1;
  localparam int TMRWO_ST_MB = 2;

  typedef enum logic [2:0] {
    TMRWO_WM_NORMAL = 3'd0,
    TMRWO_WM_PC_FF = 3'd1,
    TMRWO_WM_CTC = 3'd2,
    TMRWO_WM_FAST_FF = 3'd3,
    TMRWO_WM_RSV4 = 3'd4,
    TMRWO_WM_PC_CMP = 3'd5,
    TMRWO_WM_RSV6 = 3'd6,
    TMRWO_WM_FAST_CMP = 3'd7
  } tmrwo_wave_mode_t;

  // counting direction; gray: one bit differs
  typedef enum logic [0:0] {
    TMRWO_DIR_UP = 1'b0,
    TMRWO_DIR_DOWN = 1'b1
  } tmrwo_dir_t;

  typedef struct packed {
    logic [7:0] ctrl_a;
    logic wave_mode_high_bit;
    logic [7:0] count_value;
    logic [7:0] cmp_value_a;
    logic [7:0] cmp_value_b;
    logic [7:0] cmp_buf_a;
    logic [7:0] cmp_buf_b;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [1:0] port_dir;
    tmrwo_dir_t dir;
    logic wave_out_a;
    logic wave_out_b;
    logic block_match;
    logic ack;
    logic [7:0] rdata;
  } tmrwo_state_t;

  typedef struct packed {
    logic [1:0] pin_o;
    logic [1:0] pin_oe_n;
  } tmrwo_pins_t;
endpackage : tmrwo_pkg

// ==== hw/tmrwo_timer8.sv ====
`timescale 1ns/1ps
// What this block does
// [RULE1] counter runs on clk_i only; tick input is a one-cycle enable
// [RULE2] nonzero output-mode field makes the waveform replace the port function
// [RULE3] pin driver enabled only when that pin's direction bit is output
// [RULE4] non-PWM: 0 off, 1 toggle, 2 clear, 3 set on match
// [RULE5] fast PWM A: mode 1 toggles if high mode bit, 2/3 clear/set, invert at bottom
// [RULE6] fast PWM B: mode 1 reserved; 2 clear-match set-bottom; 3 inverse
// [RULE7] phase PWM A: mode 1 toggles if high bit; 2 clear up set down; 3 inverse
// [RULE8] phase PWM B: mode 1 reserved; 2 clear up set down; 3 inverse
// [RULE9] fast PWM, compare at top with high out bit: skip match, act at bottom
// [RULE10] phase PWM, compare at top with high out bit: skip match, act at top
// [RULE11] control A bits 3 and 2 always read zero
// [RULE12] wave mode is control A bits 1:0 plus high bit in control B
// [RULE13] modes: 0 normal,1 pc ff,2 ctc,3 fast ff,5 pc cmpA,7 fast cmpA
// [RULE14] compare update and overflow flag timing depend on the wave mode
// [RULE15] normal mode overflow flag sets on the tick wrapping max to zero
// [RULE16] ctc: counter clears on the tick after equal to compare A, flag set
// [RULE17] phase modes count up to top, hold one tick, count down
module tmrwo_timer8
  import tmrwo_pkg::*;
(
  input wire logic clk_i, // 250 MHz system clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic tick_i, // prescaled timer tick, one-cycle enable
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [TMRWO_ADDR_W-1:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte selects
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  output logic irq_o, // level interrupt
  output tmrwo_pins_t pins_o // waveform pin drive and enables
);
  tmrwo_state_t s_r;
  tmrwo_state_t s_nxt;

  logic [2:0] wm;
  logic [7:0] top;
  logic is_fast;
  logic is_pc;
  logic at_top;
  logic at_bot;
  logic req;
  logic wr;
  logic rd_hit;
  logic [7:0] widx;
  logic [7:0] wb0;
  logic ovf_ev;
  logic ma_ev;
  logic mb_ev;
  logic upd_now;
  logic nxt_a;
  logic nxt_b;
  logic oe_n_a;
  logic oe_n_b;
  logic [2:0] stat_clr;
  logic [2:0] stat_nxt;

  always_comb begin
    wm = {s_r.wave_mode_high_bit, s_r.ctrl_a[TMRWO_A_WAVE_LSB +: 2]}; // [RULE12]
    is_fast = (wm == TMRWO_WM_FAST_FF) || (wm == TMRWO_WM_FAST_CMP); // [RULE13]
    is_pc = (wm == TMRWO_WM_PC_FF) || (wm == TMRWO_WM_PC_CMP);
    top = (wm == TMRWO_WM_CTC || wm == TMRWO_WM_PC_CMP || wm == TMRWO_WM_FAST_CMP)
        ? s_r.cmp_value_a : TMRWO_MAX;
    at_top = s_r.count_value == top;
    at_bot = s_r.count_value == TMRWO_BOTTOM;
    req = wb_cyc_i && wb_stb_i && !s_r.ack;
    wr = req && wb_we_i && wb_sel_i[0];
    widx = wb_adr_i[TMRWO_ADDR_W-1:2];
    wb0 = wb_dat_i[7:0];
    stat_clr = (wr && widx == TMRWO_IDX_IRQ_STAT) ? wb0[2:0] : 3'h0;
    // decoded here, apart from the state update, so the status bits form no loop
    if (!tick_i) begin
      ovf_ev = 1'b0;
    end else if (is_pc) begin
      ovf_ev = (s_r.dir == TMRWO_DIR_DOWN) && at_bot; // [RULE14]
    end else if (wm == TMRWO_WM_FAST_CMP) begin
      ovf_ev = at_top; // [RULE14]
    end else begin
      ovf_ev = s_r.count_value == TMRWO_MAX; // [RULE15]
    end
  end

  tmrwo_wave_ch #(
    .CH_IS_A(1'b1)
  ) wave_ch_a_i (
    .tick_i(tick_i),
    .blocked_i(s_r.block_match),
    .count_i(s_r.count_value),
    .cmp_i(s_r.cmp_value_a),
    .top_i(top),
    .om_i(s_r.ctrl_a[TMRWO_A_OUTA_LSB +: 2]),
    .hi_i(s_r.wave_mode_high_bit),
    .fast_i(is_fast),
    .pc_i(is_pc),
    .down_i(s_r.dir == TMRWO_DIR_DOWN),
    .cur_i(s_r.wave_out_a),
    .dir_out_i(s_r.port_dir[1]),
    .match_o(ma_ev),
    .nxt_o(nxt_a),
    .oe_n_o(oe_n_a)
  );

  tmrwo_wave_ch #(
    .CH_IS_A(1'b0)
  ) wave_ch_b_i (
    .tick_i(tick_i),
    .blocked_i(s_r.block_match),
    .count_i(s_r.count_value),
    .cmp_i(s_r.cmp_value_b),
    .top_i(top),
    .om_i(s_r.ctrl_a[TMRWO_A_OUTB_LSB +: 2]),
    .hi_i(s_r.wave_mode_high_bit),
    .fast_i(is_fast),
    .pc_i(is_pc),
    .down_i(s_r.dir == TMRWO_DIR_DOWN),
    .cur_i(s_r.wave_out_b),
    .dir_out_i(s_r.port_dir[0]),
    .match_o(mb_ev),
    .nxt_o(nxt_b),
    .oe_n_o(oe_n_b)
  );

  tmrwo_sticky stat_ovf_i (
    .cur_i(s_r.irq_stat[TMRWO_ST_OVF]),
    .clr_i(stat_clr[TMRWO_ST_OVF]),
    .set_i(ovf_ev),
    .nxt_o(stat_nxt[TMRWO_ST_OVF])
  );

  tmrwo_sticky stat_ma_i (
    .cur_i(s_r.irq_stat[TMRWO_ST_MA]),
    .clr_i(stat_clr[TMRWO_ST_MA]),
    .set_i(ma_ev),
    .nxt_o(stat_nxt[TMRWO_ST_MA])
  );

  tmrwo_sticky stat_mb_i (
    .cur_i(s_r.irq_stat[TMRWO_ST_MB]),
    .clr_i(stat_clr[TMRWO_ST_MB]),
    .set_i(mb_ev),
    .nxt_o(stat_nxt[TMRWO_ST_MB])
  );

  always_comb begin
    s_nxt = s_r;
    rd_hit = 1'b1;
    upd_now = 1'b0;
    s_nxt.ack = req;
    s_nxt.block_match = s_r.block_match && !tick_i;

    // counter and waveform advance only on the tick enable
    if (tick_i) begin // [RULE1]
      s_nxt.wave_out_a = nxt_a;
      s_nxt.wave_out_b = nxt_b;
      if (is_pc) begin // [RULE17]
        if (s_r.dir == TMRWO_DIR_UP) begin
          if (at_top) begin
            s_nxt.dir = TMRWO_DIR_DOWN;
            upd_now = 1'b1; // [RULE14]
          end else begin
            s_nxt.count_value = s_r.count_value + 8'h01;
          end
        end else if (at_bot) begin
          s_nxt.dir = TMRWO_DIR_UP;
          s_nxt.count_value = s_r.count_value + 8'h01;
        end else begin
          s_nxt.count_value = s_r.count_value - 8'h01;
        end
      end else begin
        s_nxt.dir = TMRWO_DIR_UP;
        if (at_top && wm != TMRWO_WM_NORMAL) begin // [RULE16]
          s_nxt.count_value = TMRWO_BOTTOM;
          upd_now = (wm == TMRWO_WM_FAST_FF) || (wm == TMRWO_WM_FAST_CMP); // [RULE14]
        end else begin
          s_nxt.count_value = s_r.count_value + 8'h01;
        end
      end
      if (upd_now) begin
        s_nxt.cmp_value_a = s_r.cmp_buf_a;
        s_nxt.cmp_value_b = s_r.cmp_buf_b;
      end
    end

    if (wr) begin
      case (widx)
        TMRWO_IDX_CTRL_A: s_nxt.ctrl_a = wb0 & TMRWO_CTRL_A_WMASK; // [RULE11]
        TMRWO_IDX_CTRL_B: s_nxt.wave_mode_high_bit = wb0[TMRWO_B_WAVE_HI];
        TMRWO_IDX_COUNT: begin
          s_nxt.count_value = wb0;
          s_nxt.block_match = 1'b1;
        end
        TMRWO_IDX_CMP_A: s_nxt.cmp_buf_a = wb0;
        TMRWO_IDX_CMP_B: s_nxt.cmp_buf_b = wb0;
        TMRWO_IDX_IRQ_MASK: s_nxt.irq_mask = wb0[2:0];
        TMRWO_IDX_PORT: s_nxt.port_dir = wb0[1:0];
        default: s_nxt.ack = req;
      endcase
    end

    // modes 0 and 2 take compare writes at once; reserved modes do too
    if (!is_pc && !is_fast) begin // [RULE14]
      s_nxt.cmp_value_a = s_nxt.cmp_buf_a;
      s_nxt.cmp_value_b = s_nxt.cmp_buf_b;
    end

    // write-one-to-clear, a same-cycle event wins
    s_nxt.irq_stat = stat_nxt; // [RULE16]

    case (widx)
      TMRWO_IDX_CTRL_A: s_nxt.rdata = s_r.ctrl_a & TMRWO_CTRL_A_WMASK; // [RULE11]
      TMRWO_IDX_CTRL_B: s_nxt.rdata = {4'h0, s_r.wave_mode_high_bit, 3'h0};
      TMRWO_IDX_COUNT: s_nxt.rdata = s_r.count_value;
      TMRWO_IDX_CMP_A: s_nxt.rdata = s_r.cmp_buf_a;
      TMRWO_IDX_CMP_B: s_nxt.rdata = s_r.cmp_buf_b;
      TMRWO_IDX_IRQ_STAT: s_nxt.rdata = {5'h00, s_r.irq_stat};
      TMRWO_IDX_IRQ_MASK: s_nxt.rdata = {5'h00, s_r.irq_mask};
      TMRWO_IDX_PORT: s_nxt.rdata = {6'h00, s_r.port_dir};
      default: rd_hit = 1'b0;
    endcase
    if (!rd_hit || !req) begin
      s_nxt.rdata = TMRWO_RESET_VAL;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_ack_o = s_r.ack;
  assign wb_dat_o = {24'h00_0000, s_r.rdata};
  assign irq_o = |(s_r.irq_stat & s_r.irq_mask);

  always_comb begin
    // pin driven only while the channel is connected and the direction bit is output
    pins_o.pin_o[1] = s_r.wave_out_a;
    pins_o.pin_o[0] = s_r.wave_out_b;
    pins_o.pin_oe_n[1] = oe_n_a; // [RULE2] [RULE3]
    pins_o.pin_oe_n[0] = oe_n_b; // [RULE2] [RULE3]
  end
endmodule : tmrwo_timer8

// one compare channel: match detect, next output level and pin enable
module tmrwo_wave_ch
  import tmrwo_pkg::*;
#(
  parameter bit CH_IS_A = 1'b1 // channel a allows toggling in pwm modes
)
(
  input wire logic tick_i, // timer tick enable
  input wire logic blocked_i, // match blocked after a counter write
  input wire logic [7:0] count_i, // counter value
  input wire logic [7:0] cmp_i, // active compare value
  input wire logic [7:0] top_i, // current top value
  input wire logic [1:0] om_i, // output-mode field
  input wire logic hi_i, // wave mode high bit
  input wire logic fast_i, // fast pwm mode
  input wire logic pc_i, // phase correct pwm mode
  input wire logic down_i, // counter is counting down
  input wire logic cur_i, // registered output level
  input wire logic dir_out_i, // pin direction bit, one is output
  output logic match_o, // compare match on this tick
  output logic nxt_o, // output level after this tick
  output logic oe_n_o // pin driver enable, active low
);
  logic at_top;
  logic cmp_is_top;
  logic act_level;

  always_comb begin
    at_top = count_i == top_i;
    cmp_is_top = cmp_i == top_i;
    // mode 2 drives zero on a match, mode 3 drives one; the other point takes the inverse
    act_level = om_i[0];
    match_o = tick_i && !blocked_i && (count_i == cmp_i);
    nxt_o = cur_i;
    if (tick_i) begin
      if (!fast_i && !pc_i) begin
        if (match_o) begin // [RULE4]
          case (om_i)
            2'd1: nxt_o = ~cur_i;
            2'd2: nxt_o = 1'b0;
            2'd3: nxt_o = 1'b1;
            default: nxt_o = cur_i;
          endcase
        end
      end else begin
        case (om_i)
          2'd1: begin
            // channel b treats this code as reserved and leaves its level alone
            if (CH_IS_A && hi_i && match_o) begin // [RULE5] [RULE7] [RULE6] [RULE8]
              nxt_o = ~cur_i;
            end
          end
          2'd2, 2'd3: begin
            if (fast_i) begin
              if (cmp_is_top) begin
                // a match at top would fight the bottom action, so only bottom acts
                if (at_top) begin // [RULE9]
                  nxt_o = ~act_level;
                end
              end else if (match_o) begin // [RULE5] [RULE6]
                nxt_o = act_level;
              end else if (at_top) begin
                // bottom action lands on the tick that clears the counter
                nxt_o = ~act_level;
              end
            end else begin
              if (cmp_is_top) begin
                if (at_top) begin // [RULE10]
                  nxt_o = act_level;
                end
              end else if (match_o) begin // [RULE7] [RULE8]
                nxt_o = down_i ? ~act_level : act_level;
              end
            end
          end
          default: nxt_o = cur_i;
        endcase
      end
    end
    oe_n_o = !((|om_i) && dir_out_i); // [RULE2] [RULE3]
  end
endmodule : tmrwo_wave_ch

// one sticky status bit: write one clears, a same-cycle event wins
module tmrwo_sticky (
  input wire logic cur_i, // registered flag
  input wire logic clr_i, // write-one-to-clear strobe
  input wire logic set_i, // hardware event
  output logic nxt_o // flag value after this cycle
);
  always_comb begin
    nxt_o = (cur_i && !clr_i) || set_i;
  end
endmodule : tmrwo_sticky

// ==== bench/tmrwo_props.sv ====
`timescale 1ns/1ps
module tmrwo_props
  import tmrwo_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic rst_i, // sync reset
  input wire logic tick_i, // timer tick enable
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write enable
  input wire logic [TMRWO_ADDR_W-1:0] wb_adr_i, // address
  input wire logic [3:0] wb_sel_i, // byte selects
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // acknowledge
  input wire logic irq_o, // interrupt
  input wire tmrwo_pins_t pins_o // pin drive
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic take;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  property p_ack_next; take |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack one cycle after request");
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held longer than one cycle");
  property p_hi_zero; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper read bytes not zero");
  property p_rsv_zero;
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == {TMRWO_IDX_CTRL_A, 2'b00}
      |-> wb_dat_o[3:2] == 2'b00;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits read one");
  property p_unmapped; wb_ack_o && $past(wb_adr_i) == 10'h3fc |-> wb_dat_o == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_oe_cause; $changed(pins_o.pin_oe_n) |-> $past(take && wb_we_i); endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("enable moved without write");
  property p_pin_cause;
    $changed(pins_o.pin_o) |-> $past(tick_i) || $past(take && wb_we_i);
  endproperty
  a_pin_cause: assert property (p_pin_cause) else $error("wave moved without tick");
  property p_irq_cause; $rose(irq_o) |-> $past(tick_i) || $past(take && wb_we_i); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq rose without cause");
  c_irq: cover property ($rose(irq_o));
  c_pin: cover property ($changed(pins_o.pin_o));
  c_rd: cover property (wb_ack_o && !wb_we_i);
endmodule : tmrwo_props

// ==== bench/tmrwo_pin_model.sv ====
`timescale 1ns/1ps
module tmrwo_pin_model
  import tmrwo_pkg::*;
(
  input wire tmrwo_pins_t pins_i, // timer pin drive
  output logic [1:0] pad_o // resolved pad level
);
  // a released pad is pulled up on the board, so it never echoes the last value
  assign pad_o = pins_i.pin_o | pins_i.pin_oe_n;
endmodule : tmrwo_pin_model

// ==== bench/tmrwo_timer8_tb.sv ====
`timescale 1ns/1ps
module tmrwo_timer8_tb;
  import tmrwo_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic tick_i = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rd;
  logic [31:0] dat;
  logic ack;
  logic irq;
  tmrwo_pins_t pins;
  logic [1:0] pad;
  int n_mismatch = 0;
  int check_count = 0;
  tmrwo_timer8 tmrwo_timer8_i (.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
    .wb_dat_o(dat), .wb_ack_o(ack), .irq_o(irq), .pins_o(pins));
  tmrwo_pin_model tmrwo_pin_model_i (.pins_i(pins), .pad_o(pad));
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  task final_report;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    k = 0;
    @(posedge clk_i);
    while (ack !== 1'b1 && k < 20) begin
      @(posedge clk_i);
      k++;
    end
    if (k == 20) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t no ack", $time);
      final_report();
    end
    rd = dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task tick(input int n);
    repeat (n) begin
      @(posedge clk_i) tick_i <= 1'b1;
      @(posedge clk_i) tick_i <= 1'b0;
    end
    #1;
  endtask : tick
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(pins, 32'h3);
    wb(1, TMRWO_IDX_CTRL_A, 8'hff);
    wb(0, TMRWO_IDX_CTRL_A, 8'h0);
    chk(rd, 32'h0000_00f3);
    wb(1, TMRWO_IDX_CTRL_B, 8'hff);
    wb(0, TMRWO_IDX_CTRL_B, 8'h0);
    chk(rd, 32'h0000_0008);
    wb(0, 8'hff, 8'h0);
    chk(rd, 32'h0);
    wb(1, TMRWO_IDX_CTRL_B, 8'h0);
    wb(1, TMRWO_IDX_CTRL_A, 8'h0);
    wb(1, TMRWO_IDX_CMP_A, 8'h80);
    wb(1, TMRWO_IDX_CMP_B, 8'h80);
    wb(1, TMRWO_IDX_COUNT, 8'hfe);
    wb(1, TMRWO_IDX_IRQ_STAT, 8'h07);
    tick(1);
    wb(0, TMRWO_IDX_IRQ_STAT, 8'h0);
    chk(rd, 32'h0);
    tick(1);
    wb(0, TMRWO_IDX_IRQ_STAT, 8'h0);
    chk(rd, 32'h1);
    chk(irq, 32'h0);
    wb(1, TMRWO_IDX_IRQ_MASK, 8'h01);
    chk(irq, 32'h1);
    wb(1, TMRWO_IDX_IRQ_STAT, 8'h01);
    chk(irq, 32'h0);
    wb(1, TMRWO_IDX_PORT, 8'h03);
    wb(1, TMRWO_IDX_CMP_A, 8'h03);
    for (int m = 1; m < 4; m++) begin
      wb(1, TMRWO_IDX_CTRL_A, 8'(m * 64 + 2));
      wb(1, TMRWO_IDX_COUNT, 8'h0);
      tick(4);
      chk(pad[1], 32'(m != 2));
      chk(pins.pin_oe_n[1], 32'h0);
      wb(0, TMRWO_IDX_COUNT, 8'h0);
      chk(rd, 32'h0);
    end
    wb(0, TMRWO_IDX_IRQ_STAT, 8'h0);
    chk(rd[1], 32'h1);
    wb(1, TMRWO_IDX_PORT, 8'h0);
    chk(pins.pin_oe_n, 32'h3);
    chk(pad[1], 32'h1);
    wb(1, TMRWO_IDX_PORT, 8'h03);
    wb(1, TMRWO_IDX_CMP_B, 8'hfe);
    wb(1, TMRWO_IDX_CTRL_A, 8'h23);
    wb(1, TMRWO_IDX_COUNT, 8'hfc);
    tick(4);
    chk(pad[0], 32'h1);
    wb(1, TMRWO_IDX_CMP_B, 8'hff);
    tick(255);
    chk(pad[0], 32'h0);
    tick(257);
    chk(pad[0], 32'h1);
    wb(1, TMRWO_IDX_CTRL_A, 8'h00);
    wb(1, TMRWO_IDX_CMP_B, 8'h10);
    wb(1, TMRWO_IDX_CTRL_A, 8'h21);
    wb(1, TMRWO_IDX_COUNT, 8'h00);
    tick(18);
    chk(pad[0], 32'h0);
    tick(478);
    chk(pad[0], 32'h1);
    wb(0, TMRWO_IDX_COUNT, 8'h0);
    chk(rd, 32'h0000_000f);
    final_report();
  end
endmodule : tmrwo_timer8_tb
bind tmrwo_timer8 tmrwo_props tmrwo_props_i (.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .irq_o(irq_o), .pins_o(pins_o));
